// ### core/hpc_pkg.sv
// Purpose: constants and types for the host port configuration fields
// Assumes: one 32-bit configuration word reached by host control writes
// Notes: only bits 11:6 of the word live here; other bits read as zero
package hpc_pkg;
   // ==========================================
   // register map
   localparam logic [15:0] CFG_WORD_ADDR = 16'h0004;
   localparam int THRESH_LSB = 10;
   localparam int TX_CT_BIT = 9;
   localparam int RX_CT_BIT = 8;
   localparam int TS_EN_BIT = 7;
   localparam int TS_SIZE_BIT = 6;
   localparam int CREDIT_W = 8;

   // ==========================================
   // field carriers
   typedef struct packed {
      logic [1:0] thresh;
      logic tx_ct;
      logic rx_ct;
      logic ts_en;
      logic ts_size;
   } cfg_fields_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic rx_en;
      logic tx_en;
      logic wide;
      logic [6:0] width;
   } ts_ctrl_t;

   // ==========================================
   // reset values and decoded figures
   localparam cfg_fields_t CFG_RESET = cfg_fields_t'(6'h00);
   localparam ts_ctrl_t TS_RESET = ts_ctrl_t'(10'h000);
   localparam logic [CREDIT_W-1:0] CREDITS_CODE0 = 8'h01;
   localparam logic [CREDIT_W-1:0] CREDITS_CODE1 = 8'h04;
   localparam logic [CREDIT_W-1:0] CREDITS_CODE2 = 8'h08;
   localparam logic [CREDIT_W-1:0] CREDITS_CODE3 = 8'h10;
   localparam logic [6:0] TS_WIDTH_NARROW = 7'h20;
   localparam logic [6:0] TS_WIDTH_WIDE = 7'h40;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage

// ### core/credit_threshold.sv
// Purpose: free transmit credit level compare for the interrupt
// Assumes: credit count comes from logic on the same clock
// Notes: output is a registered level, one cycle behind its inputs
`timescale 1ns/100ps
module credit_threshold
   import hpc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // compare inputs
   input wire logic [1:0] threshold_code_i,
   input wire logic [CREDIT_W-1:0] credit_count_i,
   input wire logic enable_i,
   // level out
   output logic irq_o
);
   // ==========================================
   // threshold decode
   function automatic logic [CREDIT_W-1:0] credits_needed(input logic [1:0] code);
      case (code)
         2'h0: credits_needed = CREDITS_CODE0;
         2'h1: credits_needed = CREDITS_CODE1;
         2'h2: credits_needed = CREDITS_CODE2;
         default: credits_needed = CREDITS_CODE3;
      endcase
   endfunction

   logic irq_reg;
   logic irq_next;

   // compare only while the chunk protocol runs
   always_comb begin
      irq_next = enable_i && (credit_count_i >= credits_needed(threshold_code_i));
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   assign irq_o = irq_reg;

   // ==========================================
   // checks
   irq_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $past(reset_n_i) |-> irq_o == $past(enable_i && (credit_count_i >= credits_needed(threshold_code_i))))
      else $error("credit irq level wrong");
   irq_code3_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (enable_i && threshold_code_i == 2'h3 && credit_count_i == 8'h0f) |=> !irq_o)
      else $error("irq raised below sixteen credits");
endmodule

// ### core/host_port_config_fields.sv
// Purpose: cut-through, timestamp and credit threshold fields of the config word
// Assumes: host control access arrives as one-cycle read or write requests
// Notes: read data returns one cycle after the request; other bits read zero
`timescale 1ns/100ps
module host_port_config_fields
   import hpc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // host control access
   input wire reg_req_t reg_req_i,
   output logic [31:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // frame buffer side
   input wire logic [CREDIT_W-1:0] transmit_credit_count_i,
   input wire logic chunk_protocol_i,
   output logic tx_credit_irq_o,
   // path selects
   output logic tx_cut_through_o,
   output logic rx_cut_through_o,
   // timestamp format
   output logic rx_timestamp_enable_o,
   output logic tx_timestamp_enable_o,
   output logic timestamp_64bit_o,
   output logic [6:0] timestamp_width_o
);
   // ==========================================
   // address decode
   function automatic logic hits_cfg(input logic [15:0] addr);
      hits_cfg = (addr == CFG_WORD_ADDR);
   endfunction

   function automatic logic [31:0] pack_word(input cfg_fields_t f);
      logic [31:0] w;
      w = RDATA_RESET;
      w[THRESH_LSB +: 2] = f.thresh;
      w[TX_CT_BIT] = f.tx_ct;
      w[RX_CT_BIT] = f.rx_ct;
      w[TS_EN_BIT] = f.ts_en;
      w[TS_SIZE_BIT] = f.ts_size;
      pack_word = w;
   endfunction

   // ==========================================
   // configuration fields
   cfg_fields_t cfg_reg;
   cfg_fields_t cfg_next;

   // full-word write; no byte lanes on the control path
   always_comb begin
      cfg_next = cfg_reg;
      if (reg_req_i.wr && hits_cfg(reg_req_i.addr)) begin
         cfg_next.thresh = reg_req_i.wdata[THRESH_LSB +: 2];
         cfg_next.tx_ct = reg_req_i.wdata[TX_CT_BIT];
         cfg_next.rx_ct = reg_req_i.wdata[RX_CT_BIT];
         cfg_next.ts_en = reg_req_i.wdata[TS_EN_BIT];
         cfg_next.ts_size = reg_req_i.wdata[TS_SIZE_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cfg_reg <= CFG_RESET;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   // ==========================================
   // read return
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic rvalid_reg;
   logic rvalid_next;

   // unmapped addresses answer zero so a stray read is harmless
   always_comb begin
      rvalid_next = reg_req_i.rd;
      rdata_next = RDATA_RESET;
      if (reg_req_i.rd && hits_cfg(reg_req_i.addr)) begin
         rdata_next = pack_word(cfg_reg);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rdata_reg <= RDATA_RESET;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign reg_rvalid_o = rvalid_reg;

   // ==========================================
   // timestamp control
   ts_ctrl_t ts_reg;
   ts_ctrl_t ts_next;

   // built from the next fields so it tracks the config word exactly
   always_comb begin
      ts_next.rx_en = cfg_next.ts_en;
      ts_next.tx_en = cfg_next.ts_en;
      ts_next.wide = cfg_next.ts_en && cfg_next.ts_size;
      if (!cfg_next.ts_en) begin
         ts_next.width = 7'h00;
      end else if (cfg_next.ts_size) begin
         ts_next.width = TS_WIDTH_WIDE;
      end else begin
         ts_next.width = TS_WIDTH_NARROW;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ts_reg <= TS_RESET;
      end else begin
         ts_reg <= ts_next;
      end
   end

   assign rx_timestamp_enable_o = ts_reg.rx_en;
   assign tx_timestamp_enable_o = ts_reg.tx_en;
   assign timestamp_64bit_o = ts_reg.wide;
   assign timestamp_width_o = ts_reg.width;

   // ==========================================
   // path selects
   // rx select is not gated by protocol: the host keeps it clear in generic mode
   assign tx_cut_through_o = cfg_reg.tx_ct;
   assign rx_cut_through_o = cfg_reg.rx_ct;

   // ==========================================
   // credit interrupt
   // the compare is registered, so the level lags credits and code by one edge
   credit_threshold u_credit (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .threshold_code_i(cfg_reg.thresh),
      .credit_count_i(transmit_credit_count_i),
      .enable_i(chunk_protocol_i),
      .irq_o(tx_credit_irq_o)
   );

   // ==========================================
   // checks
   // write path: stored value, hold and read back
   wr_takes_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (reg_req_i.wr && hits_cfg(reg_req_i.addr)) |=> (pack_word(cfg_reg) == ($past(reg_req_i.wdata) & 32'h0000_0fc0)))
      else $error("config write not stored");
   field_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !(reg_req_i.wr && hits_cfg(reg_req_i.addr)) |=> $stable(cfg_reg))
      else $error("config changed without write");
   read_back_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (reg_req_i.rd && hits_cfg(reg_req_i.addr)) |=> (reg_rvalid_o && reg_rdata_o == pack_word($past(cfg_reg))))
      else $error("read data wrong");
   tx_path_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (reg_req_i.wr && hits_cfg(reg_req_i.addr)) |=> tx_cut_through_o == $past(reg_req_i.wdata[TX_CT_BIT]))
      else $error("tx cut-through select wrong");
   rx_path_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (reg_req_i.wr && hits_cfg(reg_req_i.addr)) |=> rx_cut_through_o == $past(reg_req_i.wdata[RX_CT_BIT]))
      else $error("rx cut-through select wrong");
   // timestamp control follows the stored enable and size
   ts_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !cfg_reg.ts_en |-> !(rx_timestamp_enable_o || tx_timestamp_enable_o || timestamp_64bit_o))
      else $error("timestamps on while disabled");
   ts_size_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      cfg_reg.ts_en |-> (timestamp_64bit_o == cfg_reg.ts_size && tx_timestamp_enable_o))
      else $error("timestamp size not followed");
   ts_width_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      cfg_reg.ts_en |-> timestamp_width_o == (cfg_reg.ts_size ? 7'h40 : 7'h20))
      else $error("timestamp width wrong");
   irq_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !chunk_protocol_i |=> !tx_credit_irq_o)
      else $error("credit irq outside chunk protocol");
   reset_clear_a: assert property (@(posedge clk_i)
      !reset_n_i |=> (cfg_reg == CFG_RESET && !tx_credit_irq_o))
      else $error("fields not cleared by reset");

   // read port shape: one answer per request, idle data is zero
   rvalid_pulse_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !reg_req_i.rd |=> !reg_rvalid_o)
      else $error("read valid without request");
   rdata_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !reg_req_i.rd |=> reg_rdata_o == 32'h0000_0000)
      else $error("read data not zero when idle");
   unmapped_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (reg_req_i.rd && !hits_cfg(reg_req_i.addr)) |=> reg_rdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   spare_bits_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (reg_rdata_o & 32'hFFFF_F03F) == 32'h0000_0000)
      else $error("bits outside the fields read back set");

   // both stamp directions switch on the one enable; width zero when off
   ts_pair_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      cfg_reg.ts_en |-> (rx_timestamp_enable_o && tx_timestamp_enable_o))
      else $error("timestamps off while enabled");
   ts_width_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !cfg_reg.ts_en |-> timestamp_width_o == 7'h00)
      else $error("timestamp width set while disabled");

   // sixteen credits satisfy every code; zero credits satisfy none
   irq_full_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (chunk_protocol_i && transmit_credit_count_i >= CREDITS_CODE3) |=> tx_credit_irq_o)
      else $error("credit irq missing at sixteen credits");
   irq_empty_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (transmit_credit_count_i == 8'h00) |=> !tx_credit_irq_o)
      else $error("credit irq with no free credits");

   // every output but the credit irq (checked above) back at its idle value one edge after reset
   reset_outs_a: assert property (@(posedge clk_i)
      !reset_n_i |=> ({tx_cut_through_o, rx_cut_through_o, rx_timestamp_enable_o, tx_timestamp_enable_o,
         timestamp_64bit_o, timestamp_width_o, reg_rvalid_o, reg_rdata_o} == '0))
      else $error("outputs not cleared by reset");

   // main scenarios reached
   wide_ts_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) timestamp_64bit_o);
   both_ct_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) tx_cut_through_o && rx_cut_through_o);
   irq_hi_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) tx_credit_irq_o && cfg_reg.thresh == 2'h3);
   readback_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) reg_rvalid_o && reg_rdata_o != 32'h0000_0000);
   narrow_ts_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) tx_timestamp_enable_o && !timestamp_64bit_o);
endmodule

// ### sim/host_model.sv
// Purpose: host side register access model for the configuration word
// Assumes: requests are one-cycle pulses taken at the rising edge
// Notes: idle address and data are inverted so a stale request never looks valid
`timescale 1ns/100ps
module host_model
   import hpc_pkg::*;
(
   // clock and mode
   input wire logic clk_i,
   input wire logic chunk_protocol_i,
   // register port
   output reg_req_t reg_req_o,
   input wire logic [31:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   // ==========================================
   // access tasks
   initial reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: 16'h0000, wdata: 32'h0000_0000};

   // one write pulse; requests are one idle cycle apart
   task automatic write(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] w;
      w = d;
      if (!chunk_protocol_i) begin
         w[RX_CT_BIT] = 1'b0;
      end
      @(posedge clk_i);
      #1 reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
      @(posedge clk_i);
      #1 reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~w};
   endtask

   // one read pulse; answer taken one cycle later
   task automatic read(input logic [15:0] a, output logic [31:0] d, output logic ok);
      @(posedge clk_i);
      #1 reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge clk_i);
      #1 reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'hFFFF_FFFF};
      ok = reg_rvalid_i;
      d = reg_rdata_i;
   endtask
endmodule

// ### sim/host_port_config_fields_test.sv
// Purpose: self-checking bench for the host port configuration fields
// Assumes: host model drives requests 1 ns after the rising edge
// Notes: expected values come from the field layout, never from the design
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
$display("Error %s expected %h seen %h", nm, ex, got); end end
module host_port_config_fields_test
   import hpc_pkg::*;
;
   // ==========================================
   // signals
   logic clk_i = 1'b0;
   logic reset_n_i;
   logic chunk;
   logic [7:0] credits;
   reg_req_t req;
   logic [31:0] rdata;
   logic rvalid, irq, tx_ct, rx_ct, rx_ts, tx_ts, ts64;
   logic [6:0] tsw;
   logic [31:0] d;
   int err_total = 0;
   int checked = 0;
   logic [7:0] thr [4] = '{8'h01, 8'h04, 8'h08, 8'h10};
   wire [11:0] outs = {tx_ct, rx_ct, rx_ts, tx_ts, ts64, tsw};

   always #4 clk_i = ~clk_i;

   // ==========================================
   // instances
   host_model u_host (.clk_i(clk_i), .chunk_protocol_i(chunk), .reg_req_o(req),
      .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
   host_port_config_fields u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_req_i(req),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .transmit_credit_count_i(credits),
      .chunk_protocol_i(chunk), .tx_credit_irq_o(irq), .tx_cut_through_o(tx_ct),
      .rx_cut_through_o(rx_ct), .rx_timestamp_enable_o(rx_ts), .tx_timestamp_enable_o(tx_ts),
      .timestamp_64bit_o(ts64), .timestamp_width_o(tsw));

   // ==========================================
   // helpers
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] ex);
      logic [31:0] v;
      logic ok;
      u_host.read(a, v, ok);
      `CHECK("rvalid", 1'b1, ok)
      `CHECK("rdata", ex, v)
   endtask

   // outputs expected for a written word; width is zero while stamps are off
   function automatic logic [11:0] outs_exp(input logic [31:0] w);
      return {w[9], w[8], w[7], w[7], w[7] & w[6], w[7] ? (w[6] ? 7'h40 : 7'h20) : 7'h00};
   endfunction

   task automatic stop_test();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ==========================================
   // sequence
   initial begin
      reset_n_i = 1'b0;
      credits = 8'h00;
      chunk = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 reset_n_i = 1'b1;
      rd_chk(CFG_WORD_ADDR, 32'h0000_0000);
      `CHECK("outputs", 12'h000, outs)
      // every cut-through and timestamp combination
      for (int i = 0; i < 16; i++) begin
         d = 32'(i) << 6;
         u_host.write(CFG_WORD_ADDR, d);
         `CHECK("outputs", outs_exp(d), outs)
         rd_chk(CFG_WORD_ADDR, d);
      end
      // each threshold code: one below, at threshold, and generic protocol
      for (int c = 0; c < 4; c++) begin
         u_host.write(CFG_WORD_ADDR, 32'(c) << 10);
         for (int k = 0; k < 3; k++) begin
            chunk = (k != 2);
            credits = (k == 0) ? thr[c] - 8'h01 : thr[c];
            repeat (2) @(posedge clk_i);
            #1 `CHECK("irq", (k == 1), irq)
         end
      end
      // other bits dropped, other addresses ignored; chunk mode so rx select is kept
      chunk = 1'b1;
      u_host.write(CFG_WORD_ADDR, 32'hFFFF_FFFF);
      rd_chk(CFG_WORD_ADDR, 32'h0000_0FC0);
      u_host.write(16'h0008, 32'h0000_0000);
      rd_chk(CFG_WORD_ADDR, 32'h0000_0FC0);
      rd_chk(16'h0008, 32'h0000_0000);
      // reset in mid-run clears every field
      reset_n_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 reset_n_i = 1'b1;
      `CHECK("outputs", 12'h000, outs)
      rd_chk(CFG_WORD_ADDR, 32'h0000_0000);
      stop_test();
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      stop_test();
   end
endmodule
